// *** bench/irq_core_model.sv ***
// Purpose: core side taker of the masked requests
// Assumes: requests are levels sampled on clk
// Notes:   no priority or vectoring, keeps the last vector only
`timescale 1ns/1ns
module irq_core_model (
  input  wire logic                   clk,     // system clock
  input  wire irq_mask_pkg::irq_vec_t irq_req, // masked requests
  output irq_mask_pkg::irq_vec_t      seen     // sampled requests
);
  // the core samples every edge; levels, so nothing is lost
  always_ff @(posedge clk) seen <= irq_req;
endmodule

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the interrupt mask bank
// Assumes: inputs change 10 ns after each rising edge
// Notes:   rows hold enable, flags and the expected requests
`timescale 1ns/1ns
module tb_top;
  logic                   clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_hit;
  logic [7:0]             sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [10:0]            f = 11'h000;
  irq_mask_pkg::irq_vec_t irq_req, seen;
  int                     fail_count = 0, tests_run = 0, cyc = 0;
  logic [26:0]            rows [9] = '{{8'hff, 11'h7ff, 8'hff}, {8'h00, 11'h7ff, 8'h00},
    {8'haa, 11'h400, 8'h80}, {8'h55, 11'h200, 8'h00}, {8'h55, 11'h095, 8'h55},
    {8'haa, 11'h24a, 8'haa}, {8'haa, 11'h095, 8'h00}, {8'h40, 11'h100, 8'h40},
    {8'h20, 11'h020, 8'h20}};
  peripheral_interrupt_mask_bank dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .flags(irq_mask_pkg::periph_flags_s'(f)), .irq_req(irq_req));
  irq_core_model core (.clk(clk), .irq_req(irq_req), .seen(seen));
  initial forever #50 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes last exactly one edge, as the port expects
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #10 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(posedge clk);
    #10 sfr_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
    @(posedge clk);
    #10 sfr_addr = a;
    sfr_rd = 1;
    @(posedge clk);
    #10 sfr_rd = 0;
    chk(sfr_rdata, exp);
    chk({7'h00, sfr_hit}, {7'h00, h});
  endtask
  task tally_and_finish();
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, run needs about 90 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #10 sys_rst = 0;
    rd(8'he6, 8'h00, 1'b1);
    for (int i = 0; i < 9; i++) begin
      wr(8'he6, rows[i][26:19]);
      f = rows[i][18:8];
      repeat (2) @(posedge clk);
      #10 chk(irq_req, rows[i][7:0]);
      chk(seen, rows[i][7:0]);
      rd(8'he6, rows[i][26:19], 1'b1);
    end
    // unmapped place must neither write nor answer
    wr(8'he7, 8'h00);
    rd(8'he6, 8'h20, 1'b1);
    rd(8'he7, 8'h00, 1'b0);
    // mask dropped under held flags, old mask shows one more cycle
    f = 11'h7ff;
    wr(8'he6, 8'h00);
    chk(irq_req, 8'h20);
    @(posedge clk);
    #10 chk(irq_req, 8'h00);
    // one-edge reset mid-run with all gates and flags up
    wr(8'he6, 8'hff);
    sys_rst = 1;
    @(posedge clk);
    #10 sys_rst = 0;
    chk(irq_req, 8'h00);
    rd(8'he6, 8'h00, 1'b1);
    chk(irq_req, 8'h00);
    tally_and_finish();
  end
endmodule

// *** verilog/irq_mask_pkg.sv ***
// Purpose: constants and carriers for the peripheral interrupt mask bank
// Assumes: 8-bit special function register space, one system clock
// Notes:   bit positions follow the enable register layout
package irq_mask_pkg;
  localparam logic [7:0] enable_1_addr  = 8'he6;
  localparam logic [7:0] enable_1_reset = 8'h00;
  localparam int         third_timer_bit   = 7;
  localparam int         second_comp_bit   = 6;
  localparam int         first_comp_bit    = 5;
  localparam int         counter_array_bit = 4;
  localparam int         conv_done_bit     = 3;
  localparam int         window_bit        = 2;
  localparam int         usb_bit           = 1;
  localparam int         smbus_bit         = 0;

  // raw request flags from the peripherals
  typedef struct packed {
    logic timer_low_overflow_flag;
    logic timer_high_overflow_flag;
    logic second_comp_rising_flag;
    logic second_comp_falling_flag;
    logic first_comp_rising_flag;
    logic first_comp_falling_flag;
    logic counter_array_req;
    logic conversion_done_flag;
    logic window_compare_flag;
    logic usb_function_req;
    logic smbus_req;
  } periph_flags_s;

  // masked requests, one per source, msb is the timer
  typedef logic [7:0] irq_vec_t;
endpackage

// *** verilog/peripheral_interrupt_mask_bank.sv ***
// Purpose: enable register that gates peripheral requests to the core
// Assumes: register port is synchronous; flags are synchronous levels
// Notes:   masked requests are registered, so they lag flags by one cycle
`timescale 1ns/1ns

// How it works
// - bit 7 forwards timer low or high overflow requests only when set
// - bit 6 forwards second comparator rising or falling requests when set
// - bit 5 forwards first comparator rising or falling requests when set
// - bit 4 gates all counter array requests together
// - bit 3 forwards the conversion done flag when set
// - bit 2 forwards the window compare flag when set
module peripheral_interrupt_mask_bank (
  input  wire logic                        clk,       // system clock
  input  wire logic                        sys_rst,   // sync reset, high
  input  wire logic [7:0]                  sfr_addr,  // register address
  input  wire logic                        sfr_wr,    // write strobe
  input  wire logic                        sfr_rd,    // read strobe
  input  wire logic [7:0]                  sfr_wdata, // write data
  output logic      [7:0]                  sfr_rdata, // read data
  output logic                             sfr_hit,   // address matched read
  input  wire irq_mask_pkg::periph_flags_s flags,     // raw peripheral flags
  output irq_mask_pkg::irq_vec_t           irq_req    // masked requests
);
  logic [7:0]             peripheral_irq_enable_1;
  logic [7:0]             next_enable;
  logic [7:0]             next_rdata;
  logic                   next_hit;
  irq_mask_pkg::irq_vec_t next_req;
  irq_mask_pkg::irq_vec_t raw;
  logic                   wr_hit;
  logic                   rd_hit;

  // one address compare shared by the write and the read path
  function automatic logic reg_selected(input logic strobe, input logic [7:0] addr);
    return strobe && (addr == irq_mask_pkg::enable_1_addr);
  endfunction

  // strobe decode; anything outside the one mapped address is ignored
  always_comb begin
    wr_hit = reg_selected(sfr_wr, sfr_addr);
    rd_hit = reg_selected(sfr_rd, sfr_addr);
  end

  // enable next value; a write replaces all eight gates in one go
  always_comb begin
    next_enable = peripheral_irq_enable_1;
    if (wr_hit) begin
      next_enable = sfr_wdata;
    end
  end

  // enable register; the only state that software can see here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peripheral_irq_enable_1 <= irq_mask_pkg::enable_1_reset;
    end else begin
      peripheral_irq_enable_1 <= next_enable;
    end
  end

  // read answer; a write in the same cycle still reads the old value
  always_comb begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (rd_hit) begin
      next_rdata = peripheral_irq_enable_1;
      next_hit   = 1'b1;
    end
  end

  // read port flops; data idles at zero so it can share an or-tree bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_rdata <= next_rdata;
      sfr_hit   <= next_hit;
    end
  end

  // merge each source's flags into one raw request, then gate it
  always_comb begin
    raw = '0;
    raw[irq_mask_pkg::third_timer_bit]   = flags.timer_low_overflow_flag |
                                           flags.timer_high_overflow_flag;
    raw[irq_mask_pkg::second_comp_bit]   = flags.second_comp_rising_flag |
                                           flags.second_comp_falling_flag;
    raw[irq_mask_pkg::first_comp_bit]    = flags.first_comp_rising_flag |
                                           flags.first_comp_falling_flag;
    raw[irq_mask_pkg::counter_array_bit] = flags.counter_array_req;
    raw[irq_mask_pkg::conv_done_bit]     = flags.conversion_done_flag;
    raw[irq_mask_pkg::window_bit]        = flags.window_compare_flag;
    raw[irq_mask_pkg::usb_bit]           = flags.usb_function_req;
    raw[irq_mask_pkg::smbus_bit]         = flags.smbus_req;
    // a clear enable bit blocks every flag of its source at once
    next_req = raw & peripheral_irq_enable_1;
  end

  // registering keeps outputs glitch free at the cost of one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req <= '0;
    end else begin
      irq_req <= next_req;
    end
  end

  // timer gate; a one-edge reset would leave stale history, hence the guard
  a_timer_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> irq_req[7] == ($past(peripheral_irq_enable_1[7]) &
      ($past(flags.timer_low_overflow_flag) | $past(flags.timer_high_overflow_flag))))
    else $error("timer request gating wrong");
  a_timer_low_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[7] && flags.timer_low_overflow_flag |=> irq_req[7])
    else $error("timer low overflow request lost");
  a_timer_high_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[7] && flags.timer_high_overflow_flag |=> irq_req[7])
    else $error("timer high overflow request lost");
  a_timer_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[7] |=> !irq_req[7])
    else $error("timer request leaked");

  // second comparator; either edge flag behind one shared gate
  a_comp2_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[6] && !$past(peripheral_irq_enable_1[6]) |-> !irq_req[6])
    else $error("second comparator request leaked");
  a_comp2_rise_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[6] && flags.second_comp_rising_flag |=> irq_req[6])
    else $error("second comparator rising request lost");
  a_comp2_fall_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[6] && flags.second_comp_falling_flag |=> irq_req[6])
    else $error("second comparator falling request lost");
  a_comp2_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !flags.second_comp_rising_flag && !flags.second_comp_falling_flag |=> !irq_req[6])
    else $error("second comparator request without flag");

  // first comparator; same shape as the second
  a_comp1_gate: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[5] && flags.first_comp_falling_flag |=> irq_req[5])
    else $error("first comparator request lost");
  a_comp1_rise_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[5] && flags.first_comp_rising_flag |=> irq_req[5])
    else $error("first comparator rising request lost");
  a_comp1_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[5] |=> !irq_req[5])
    else $error("first comparator request leaked");
  a_comp1_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !flags.first_comp_rising_flag && !flags.first_comp_falling_flag |=> !irq_req[5])
    else $error("first comparator request without flag");

  // counter array; all of its sources arrive here already merged
  a_array_gate: assert property (@(posedge clk) disable iff (sys_rst)
    irq_req[4] |-> $past(peripheral_irq_enable_1[4]) && $past(flags.counter_array_req))
    else $error("counter array request wrong");
  a_array_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[4] && flags.counter_array_req |=> irq_req[4])
    else $error("counter array request lost");
  a_array_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[4] |=> !irq_req[4])
    else $error("counter array request leaked");

  // conversion done
  a_conv_gate: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[3] && flags.conversion_done_flag |=> irq_req[3])
    else $error("conversion done request lost");
  a_conv_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[3] |=> !irq_req[3])
    else $error("conversion done request leaked");
  a_conv_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !flags.conversion_done_flag |=> !irq_req[3])
    else $error("conversion done request without flag");

  // window compare; guarded like the timer against stale history
  a_window_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> irq_req[2] ==
      ($past(peripheral_irq_enable_1[2]) & $past(flags.window_compare_flag)))
    else $error("window request gating wrong");
  a_window_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[2] && flags.window_compare_flag |=> irq_req[2])
    else $error("window request lost");
  a_window_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[2] |=> !irq_req[2])
    else $error("window request leaked");

  // usb and smbus; one aggregated request each
  a_usb_smb_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> irq_req[1:0] == ($past(peripheral_irq_enable_1[1:0]) &
      {$past(flags.usb_function_req), $past(flags.smbus_req)}))
    else $error("usb or smbus gating wrong");
  a_usb_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[1] && flags.usb_function_req |=> irq_req[1])
    else $error("usb request lost");
  a_smbus_pass: assert property (@(posedge clk) disable iff (sys_rst)
    peripheral_irq_enable_1[0] && flags.smbus_req |=> irq_req[0])
    else $error("smbus request lost");
  a_usb_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[1] |=> !irq_req[1])
    else $error("usb request leaked");
  a_smbus_block: assert property (@(posedge clk) disable iff (sys_rst)
    !peripheral_irq_enable_1[0] |=> !irq_req[0])
    else $error("smbus request leaked");

  // register port; addresses checked against the package, not the decoder
  a_write_takes: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_wr && sfr_addr == irq_mask_pkg::enable_1_addr |=>
      peripheral_irq_enable_1 == $past(sfr_wdata))
    else $error("enable write not stored");
  a_write_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    !(sfr_wr && sfr_addr == irq_mask_pkg::enable_1_addr) |=>
      $stable(peripheral_irq_enable_1))
    else $error("enable changed without a write");
  a_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_rd && sfr_addr == irq_mask_pkg::enable_1_addr |=>
      sfr_hit && sfr_rdata == $past(peripheral_irq_enable_1))
    else $error("enable read answered wrong");
  a_read_refused: assert property (@(posedge clk) disable iff (sys_rst)
    !(sfr_rd && sfr_addr == irq_mask_pkg::enable_1_addr) |=>
      !sfr_hit && sfr_rdata == 8'h00)
    else $error("read answered without a read");
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !sfr_hit |-> sfr_rdata == 8'h00)
    else $error("read data not idle");

  // reset clears every visible flop; no disable, it is the reset itself
  a_reset_clears: assert property (@(posedge clk)
    sys_rst |=> peripheral_irq_enable_1 == irq_mask_pkg::enable_1_reset &&
      irq_req == '0 && !sfr_hit && sfr_rdata == 8'h00)
    else $error("reset left state behind");
endmodule
